// *** rtl/mttc_pkg.sv ***
// constants, types and helpers for the trap and trigger register bank
// assumes 12-bit register addresses and 32-bit data
package mttc_pkg;

    localparam logic [11:0] ADDR_EXCEPTION_PC     = 12'h341;
    localparam logic [11:0] ADDR_TRAP_CAUSE       = 12'h342;
    localparam logic [11:0] ADDR_TRAP_VALUE       = 12'h343;
    localparam logic [11:0] ADDR_IRQ_PENDING      = 12'h344;
    localparam logic [11:0] ADDR_TRIGGER_SELECT   = 12'h7A0;
    localparam logic [11:0] ADDR_TRIGGER_CONTROL  = 12'h7A1;
    localparam logic [11:0] ADDR_TRIGGER_MATCH    = 12'h7A2;
    localparam logic [11:0] ADDR_TRIGGER_EXTRA    = 12'h7A3;
    localparam logic [11:0] ADDR_TRIGGER_INFO     = 12'h7A4;
    localparam logic [11:0] ADDR_MACHINE_CONTEXT  = 12'h7A8;
    localparam logic [7:0]  TRIGGER_ADDR_BLOCK    = 8'h7A;

    localparam logic [31:0] RESET_WORD            = 32'h0000_0000;
    localparam logic [31:0] EXCEPTION_PC_MASK     = 32'hFFFF_FFFE;
    localparam logic [31:0] TRAP_CAUSE_MASK       = 32'h8000_001F;
    localparam int          CAUSE_IRQ_BIT         = 31;
    localparam logic [31:0] IRQ_PENDING_MASK      = 32'hFFFF_0888;
    localparam logic [31:0] TRIGGER_CONTROL_FIXED = 32'h2800_1040;
    localparam int          EXECUTE_BIT           = 2;
    localparam logic [31:0] EXECUTE_MASK          = 32'h0000_0004;
    localparam logic [31:0] TYPE_INFO_VALUE       = 32'h0000_0004;
    localparam logic [31:0] TYPE_INFO_NONE        = 32'h0000_0001;

    typedef enum logic [1:0] {
        CSR_OP_READ,
        CSR_OP_WRITE,
        CSR_OP_SET,
        CSR_OP_CLEAR
    } mttc_csrop_type;

    function automatic logic mttc_is_trigger(input logic [11:0] addr);
        return addr[11:4] == TRIGGER_ADDR_BLOCK;
    endfunction : mttc_is_trigger

    function automatic logic [31:0] mttc_apply_op(input mttc_csrop_type op,
                                                  input logic [31:0]   old,
                                                  input logic [31:0]   wdata);
        case (op)
            CSR_OP_WRITE: return wdata;
            CSR_OP_SET:   return old | wdata;
            CSR_OP_CLEAR: return old & ~wdata;
            default:      return old;
        endcase
    endfunction : mttc_apply_op

endpackage : mttc_pkg

// *** rtl/mttc_irq_pending.sv ***
// read-only pending view of the interrupt request lines
// assumes request lines are synchronous to clk_sys
`timescale 1ns/1ns
module mttc_irq_pending (
    input  logic        clk_sys,
    input  logic        rst,
    input  logic [31:0] irqLines,
    output logic [31:0] pendingBits
);
    typedef struct packed {
        logic [31:0] pending;
    } mttc_pend_state_type;

    mttc_pend_state_type pend_ff;
    mttc_pend_state_type nxt_pend;

    always_comb begin
        nxt_pend = pend_ff;
        // level follows the line every cycle, software has no path in
        nxt_pend.pending = irqLines & mttc_pkg::IRQ_PENDING_MASK;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    assign pendingBits = pend_ff.pending;

    pending_track_a: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 pendingBits == ($past(irqLines) & mttc_pkg::IRQ_PENDING_MASK))
        else $error("pending bits do not track request lines");

endmodule : mttc_irq_pending

// *** rtl/mttc_addr_trigger.sv ***
// single instruction-address breakpoint comparator
// assumes fetch address and valid arrive in the cycle before execution
`timescale 1ns/1ns
module mttc_addr_trigger (
    input  logic        clk_sys,
    input  logic        rst,
    input  logic        fetchValid,
    input  logic [31:0] fetchAddr,
    input  logic [31:0] matchAddress,
    input  logic        executeEnable,
    input  logic        machineMode,
    input  logic        debugMode,
    output logic        breakReq
);
    // exact compare only: no mask, chain or load/store match
    always_comb begin
        breakReq = fetchValid && executeEnable && machineMode && !debugMode
                   && (fetchAddr == matchAddress);
    end

    break_on_match_a: assert property (@(posedge clk_sys) disable iff (rst)
        fetchValid && executeEnable && machineMode && !debugMode
        && fetchAddr == matchAddress |-> breakReq)
        else $error("address match did not break");

    break_needs_enable_a: assert property (@(posedge clk_sys) disable iff (rst)
        breakReq |-> executeEnable && fetchAddr == matchAddress)
        else $error("break without enable or match");

    cover_break_c: cover property (@(posedge clk_sys) disable iff (rst) breakReq);

endmodule : mttc_addr_trigger

// *** rtl/mttc_csr_bank.sv ***
// trap bookkeeping and trigger register bank of the core
// assumes one register access per cycle, mode flags and trap events from the core pipeline
`timescale 1ns/1ns
module mttc_csr_bank #(
    parameter int TriggerCount = 1
) (
    input  logic                    clk_sys,
    input  logic                    rst,
    input  logic                    csrValid,
    input  logic [11:0]             csrAddr,
    input  mttc_pkg::mttc_csrop_type csrOp,
    input  logic [31:0]             csrWdata,
    input  logic                    debugMode,
    input  logic                    machineMode,
    output logic [31:0]             csrRdata,
    output logic                    csrReadValid,
    output logic                    csrMapped,
    output logic                    csrDenied,
    input  logic                    trapTaken,
    input  logic                    trapIsIrq,
    input  logic [4:0]              trapCode,
    input  logic [31:0]             trapPc,
    input  logic                    mretValid,
    output logic                    resumeValid,
    output logic [31:0]             resumePc,
    input  logic                    irqEnableWrite,
    input  logic                    irqEnableValue,
    output logic                    irqEnable,
    output logic                    previousIrqEnable,
    input  logic [31:0]             irqLines,
    input  logic                    fetchValid,
    input  logic [31:0]             fetchAddr,
    output logic                    debugBreak
);
    typedef struct packed {
        logic [31:0] exceptionPc;
        logic [31:0] trapCause;
        logic [31:0] matchAddress;
        logic        executeEnable;
        logic        irqEnable;
        logic        prevIrqEnable;
        logic [31:0] rdata;
        logic        readValid;
        logic        mapped;
        logic        denied;
    } mttc_state_type;

    mttc_state_type s_ff;
    mttc_state_type nxt_s;
    logic [31:0]    pendingBits;
    logic [31:0]    readWord;
    logic [31:0]    newWord;
    logic           hitWord;
    logic           allowed;
    logic           writing;

    mttc_irq_pending u_pending (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .irqLines    (irqLines),
        .pendingBits (pendingBits)
    );

    mttc_addr_trigger u_trigger (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .fetchValid    (fetchValid),
        .fetchAddr     (fetchAddr),
        .matchAddress  (s_ff.matchAddress),
        .executeEnable (s_ff.executeEnable),
        .machineMode   (machineMode),
        .debugMode     (debugMode),
        .breakReq      (debugBreak)
    );

    // read mux; unmapped addresses read zero and report not mapped
    always_comb begin
        readWord = mttc_pkg::RESET_WORD;
        hitWord  = 1'b1;
        case (csrAddr)
            mttc_pkg::ADDR_EXCEPTION_PC:    readWord = s_ff.exceptionPc;
            mttc_pkg::ADDR_TRAP_CAUSE:      readWord = s_ff.trapCause & mttc_pkg::TRAP_CAUSE_MASK;
            mttc_pkg::ADDR_TRAP_VALUE:      readWord = mttc_pkg::RESET_WORD;
            mttc_pkg::ADDR_IRQ_PENDING:     readWord = pendingBits;
            mttc_pkg::ADDR_TRIGGER_SELECT:  readWord = mttc_pkg::RESET_WORD;
            mttc_pkg::ADDR_TRIGGER_CONTROL: begin
                readWord = mttc_pkg::TRIGGER_CONTROL_FIXED;
                readWord[mttc_pkg::EXECUTE_BIT] = s_ff.executeEnable;
            end
            mttc_pkg::ADDR_TRIGGER_MATCH:   readWord = s_ff.matchAddress;
            mttc_pkg::ADDR_TRIGGER_EXTRA:   readWord = mttc_pkg::RESET_WORD;
            mttc_pkg::ADDR_TRIGGER_INFO: begin
                // select is fixed at zero, so the trigger exists unless none are built
                readWord = (TriggerCount > 0) ? mttc_pkg::TYPE_INFO_VALUE
                                              : mttc_pkg::TYPE_INFO_NONE;
            end
            mttc_pkg::ADDR_MACHINE_CONTEXT: readWord = mttc_pkg::RESET_WORD;
            default: begin
                readWord = mttc_pkg::RESET_WORD;
                hitWord  = 1'b0;
            end
        endcase
    end

    always_comb begin
        allowed = !mttc_pkg::mttc_is_trigger(csrAddr) || debugMode || machineMode;
        writing = csrValid && allowed && (csrOp != mttc_pkg::CSR_OP_READ);
        newWord = mttc_pkg::mttc_apply_op(csrOp, readWord, csrWdata);
    end

    always_comb begin
        nxt_s           = s_ff;
        nxt_s.readValid = csrValid;
        nxt_s.mapped    = csrValid && hitWord;
        nxt_s.denied    = csrValid && !allowed;
        nxt_s.rdata     = (csrValid && allowed) ? readWord : mttc_pkg::RESET_WORD;

        // code values are trusted as written; illegal ones are software's problem
        if (writing) begin
            case (csrAddr)
                mttc_pkg::ADDR_EXCEPTION_PC:
                    nxt_s.exceptionPc = newWord & mttc_pkg::EXCEPTION_PC_MASK;
                mttc_pkg::ADDR_TRAP_CAUSE:
                    nxt_s.trapCause = newWord & mttc_pkg::TRAP_CAUSE_MASK;
                mttc_pkg::ADDR_TRIGGER_CONTROL: begin
                    if (debugMode) begin
                        nxt_s.executeEnable = newWord[mttc_pkg::EXECUTE_BIT];
                    end
                end
                mttc_pkg::ADDR_TRIGGER_MATCH: begin
                    if (debugMode) begin
                        nxt_s.matchAddress = newWord;
                    end
                end
                default: begin
                    // read-only words drop the write
                    nxt_s.rdata = nxt_s.rdata;
                end
            endcase
        end

        if (irqEnableWrite) begin
            nxt_s.irqEnable = irqEnableValue;
        end

        if (mretValid) begin
            nxt_s.irqEnable = s_ff.prevIrqEnable;
        end

        // hardware trap beats a same-cycle software write or return
        if (trapTaken) begin
            nxt_s.exceptionPc = trapPc & mttc_pkg::EXCEPTION_PC_MASK;
            nxt_s.trapCause   = {trapIsIrq, 26'h0, trapCode};
            nxt_s.prevIrqEnable = s_ff.irqEnable;
            nxt_s.irqEnable   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign csrRdata          = s_ff.rdata;
    assign csrReadValid      = s_ff.readValid;
    assign csrMapped         = s_ff.mapped;
    assign csrDenied         = s_ff.denied;
    assign resumeValid       = mretValid;
    assign resumePc          = s_ff.exceptionPc;
    assign irqEnable         = s_ff.irqEnable;
    assign previousIrqEnable = s_ff.prevIrqEnable;

    default clocking mttc_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    trap_pc_save_a: assert property (
        trapTaken |=> resumePc == ($past(trapPc) & mttc_pkg::EXCEPTION_PC_MASK))
        else $error("trap did not save pc");

    return_pc_a: assert property (
        trapTaken ##1 (mretValid && !trapTaken && !csrValid) |->
        resumeValid && resumePc == ($past(trapPc) & mttc_pkg::EXCEPTION_PC_MASK))
        else $error("return pc differs from saved pc");

    cause_irq_bit_a: assert property (
        trapTaken ##1 (csrValid && csrAddr == mttc_pkg::ADDR_TRAP_CAUSE && !trapTaken)
        |=> csrRdata[mttc_pkg::CAUSE_IRQ_BIT] == $past(trapIsIrq, 2)
            && csrRdata[4:0] == $past(trapCode, 2))
        else $error("cause interrupt bit or code wrong");

    cause_reserved_a: assert property (
        csrValid && csrAddr == mttc_pkg::ADDR_TRAP_CAUSE |=> csrRdata[30:5] == 26'h0)
        else $error("cause reserved bits not zero");

    trap_value_zero_a: assert property (
        csrValid && csrAddr == mttc_pkg::ADDR_TRAP_VALUE |=> csrReadValid && csrRdata == '0)
        else $error("trap value not zero");

    pending_view_a: assert property (
        ##2 csrValid && csrAddr == mttc_pkg::ADDR_IRQ_PENDING |=>
        csrRdata == ($past(irqLines, 2) & mttc_pkg::IRQ_PENDING_MASK))
        else $error("pending view does not match request lines");

    select_zero_a: assert property (
        csrValid && csrAddr == mttc_pkg::ADDR_TRIGGER_SELECT |=> csrRdata == '0)
        else $error("trigger select not zero");

    trigger_denied_a: assert property (
        csrValid && mttc_pkg::mttc_is_trigger(csrAddr) && !debugMode && !machineMode
        |=> csrDenied && csrRdata == '0)
        else $error("trigger access outside allowed modes");

    machine_write_drop_a: assert property (
        csrValid && !debugMode && csrOp != mttc_pkg::CSR_OP_READ
        && csrAddr == mttc_pkg::ADDR_TRIGGER_MATCH |=> $stable(s_ff.matchAddress))
        else $error("trigger address changed outside debug mode");

    control_fixed_a: assert property (
        csrValid && allowed && csrAddr == mttc_pkg::ADDR_TRIGGER_CONTROL |=>
        (csrRdata & ~mttc_pkg::EXECUTE_MASK) == mttc_pkg::TRIGGER_CONTROL_FIXED)
        else $error("trigger control fixed fields wrong");

    info_value_a: assert property (
        csrValid && allowed && csrAddr == mttc_pkg::ADDR_TRIGGER_INFO |=>
        csrRdata == ((TriggerCount > 0) ? mttc_pkg::TYPE_INFO_VALUE
                                        : mttc_pkg::TYPE_INFO_NONE))
        else $error("trigger info wrong");

    context_zero_a: assert property (
        csrValid && (csrAddr == mttc_pkg::ADDR_MACHINE_CONTEXT
                     || csrAddr == mttc_pkg::ADDR_TRIGGER_EXTRA) |=> csrRdata == '0)
        else $error("extra data or context not zero");

    return_enable_a: assert property (
        mretValid && !trapTaken |=> irqEnable == $past(previousIrqEnable))
        else $error("return did not restore interrupt enable");

    cover_trap_c:   cover property (trapTaken ##[1:20] mretValid);
    cover_dbg_wr_c: cover property (csrValid && debugMode && csrOp == mttc_pkg::CSR_OP_WRITE
                                    && csrAddr == mttc_pkg::ADDR_TRIGGER_MATCH);
    cover_deny_c:   cover property (csrDenied);

endmodule : mttc_csr_bank

// *** test/mttc_far_side.sv ***
// far-side model: interrupt request sources and the external debug module
// assumes the bench steers it through plain request inputs on clk_sys
`timescale 1ns/1ns
module mttc_far_side #(
    parameter int SlowHalt = 0
) (
    input  logic        clk_sys,
    input  logic        rst,
    input  logic [31:0] irqDrive,
    input  logic        haltReq,
    input  logic        resumeReq,
    input  logic        debugBreak,
    output logic [31:0] irqLines,
    output logic        debugMode
);
    logic breakSeen_ff;

    // lines leave a flop so they stay synchronous to clk_sys
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqLines     <= 32'h0000_0000;
            debugMode    <= 1'b0;
            breakSeen_ff <= 1'b0;
        end else begin
            irqLines     <= irqDrive;
            breakSeen_ff <= debugBreak;
            if (resumeReq) begin
                debugMode <= 1'b0;
            end else if (haltReq || ((SlowHalt != 0) ? breakSeen_ff : debugBreak)) begin
                debugMode <= 1'b1;
            end
        end
    end
endmodule : mttc_far_side

// *** test/mttc_csr_bank_bench.sv ***
// self-checking bench of the trap and trigger register bank
// assumes the far-side model supplies request lines and debug mode
`timescale 1ns/1ns
module mttc_csr_bank_bench;
    typedef struct {
        logic [11:0]              addr;
        mttc_pkg::mttc_csrop_type op;
        logic [31:0]              wdata;
        logic                     dbg;
        logic                     mm;
        logic [31:0]              rdata;
        logic [1:0]               flags;
    } mttc_row_type;
    localparam mttc_pkg::mttc_csrop_type RD = mttc_pkg::CSR_OP_READ;
    localparam mttc_pkg::mttc_csrop_type WR = mttc_pkg::CSR_OP_WRITE;
    localparam mttc_pkg::mttc_csrop_type ST = mttc_pkg::CSR_OP_SET;
    localparam mttc_pkg::mttc_csrop_type CL = mttc_pkg::CSR_OP_CLEAR;

    logic clk_sys, rst, csrValid, machineMode, debugMode, csrReadValid, csrMapped, csrDenied;
    logic trapTaken, trapIsIrq, mretValid, resumeValid, irqEnableWrite, irqEnableValue;
    logic irqEnable, previousIrqEnable, fetchValid, debugBreak, haltReq, resumeReq;
    logic [11:0] csrAddr;
    logic [4:0]  trapCode;
    logic [31:0] csrWdata, csrRdata, rdataNone, trapPc, resumePc, irqLines, irqDrive, fetchAddr;
    mttc_pkg::mttc_csrop_type csrOp;
    int numErrors, totalChecks;
    mttc_row_type rows[] = '{
        '{12'h341, WR, 32'hFFFFFFFF, 0, 1, 32'h00000000, 2'b10},
        '{12'h341, RD, 32'h0, 0, 1, 32'hFFFFFFFE, 2'b10},
        '{12'h342, WR, 32'hFFFFFFEB, 0, 1, 32'h00000000, 2'b10},
        '{12'h342, CL, 32'h80000000, 0, 1, 32'h8000000B, 2'b10},
        '{12'h342, RD, 32'h0, 0, 1, 32'h0000000B, 2'b10},
        '{12'h343, WR, 32'hFFFFFFFF, 0, 1, 32'h00000000, 2'b10},
        '{12'h343, RD, 32'h0, 0, 1, 32'h00000000, 2'b10},
        '{12'h344, ST, 32'hFFFFFFFF, 0, 1, 32'h00000000, 2'b10},
        '{12'h344, RD, 32'h0, 0, 1, 32'h00000000, 2'b10},
        '{12'h7A0, WR, 32'h00000001, 0, 1, 32'h00000000, 2'b10},
        '{12'h7A0, RD, 32'h0, 0, 1, 32'h00000000, 2'b10},
        '{12'h7A1, WR, 32'hFFFFFFFF, 0, 1, 32'h28001040, 2'b10},
        '{12'h7A1, RD, 32'h0, 0, 1, 32'h28001040, 2'b10},
        '{12'h7A2, WR, 32'h12345678, 0, 1, 32'h00000000, 2'b10},
        '{12'h7A2, RD, 32'h0, 0, 1, 32'h00000000, 2'b10},
        '{12'h7A1, ST, 32'hFFFFFFFF, 1, 0, 32'h28001040, 2'b10},
        '{12'h7A1, RD, 32'h0, 1, 0, 32'h28001044, 2'b10},
        '{12'h7A2, WR, 32'h80001230, 1, 1, 32'h00000000, 2'b10},
        '{12'h7A2, RD, 32'h0, 1, 1, 32'h80001230, 2'b10},
        '{12'h7A3, WR, 32'hFFFFFFFF, 1, 1, 32'h00000000, 2'b10},
        '{12'h7A3, RD, 32'h0, 1, 1, 32'h00000000, 2'b10},
        '{12'h7A8, WR, 32'hFFFFFFFF, 1, 1, 32'h00000000, 2'b10},
        '{12'h7A8, RD, 32'h0, 1, 1, 32'h00000000, 2'b10},
        '{12'h7A4, RD, 32'h0, 0, 1, 32'h00000004, 2'b10},
        '{12'h7A2, WR, 32'h00000000, 0, 0, 32'h00000000, 2'b11},
        '{12'h7A2, RD, 32'h0, 0, 1, 32'h80001230, 2'b10},
        '{12'h7A5, RD, 32'h0, 0, 1, 32'h00000000, 2'b00},
        '{12'h345, RD, 32'h0, 0, 1, 32'h00000000, 2'b00}
    };
    logic [31:0] pats[3] = '{32'hFFFFFFFF, 32'h00000808, 32'h00010080};

    mttc_csr_bank #(.TriggerCount(1)) mttc_csr_bank_i (.clk_sys(clk_sys), .rst(rst),
        .csrValid(csrValid), .csrAddr(csrAddr), .csrOp(csrOp), .csrWdata(csrWdata),
        .debugMode(debugMode), .machineMode(machineMode), .csrRdata(csrRdata),
        .csrReadValid(csrReadValid), .csrMapped(csrMapped), .csrDenied(csrDenied),
        .trapTaken(trapTaken), .trapIsIrq(trapIsIrq), .trapCode(trapCode), .trapPc(trapPc),
        .mretValid(mretValid), .resumeValid(resumeValid), .resumePc(resumePc),
        .irqEnableWrite(irqEnableWrite), .irqEnableValue(irqEnableValue), .irqEnable(irqEnable),
        .previousIrqEnable(previousIrqEnable), .irqLines(irqLines), .fetchValid(fetchValid),
        .fetchAddr(fetchAddr), .debugBreak(debugBreak));
    // no-trigger build shares every input; only its read data is looked at
    mttc_csr_bank #(.TriggerCount(0)) mttc_csr_bank_none_i (.clk_sys(clk_sys), .rst(rst),
        .csrValid(csrValid), .csrAddr(csrAddr), .csrOp(csrOp), .csrWdata(csrWdata),
        .debugMode(debugMode), .machineMode(machineMode), .csrRdata(rdataNone),
        .csrReadValid(), .csrMapped(), .csrDenied(), .trapTaken(trapTaken),
        .trapIsIrq(trapIsIrq), .trapCode(trapCode), .trapPc(trapPc), .mretValid(mretValid),
        .resumeValid(), .resumePc(), .irqEnableWrite(irqEnableWrite),
        .irqEnableValue(irqEnableValue), .irqEnable(), .previousIrqEnable(),
        .irqLines(irqLines), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .debugBreak());
    mttc_far_side #(.SlowHalt(0)) mttc_far_side_i (.clk_sys(clk_sys), .rst(rst),
        .irqDrive(irqDrive), .haltReq(haltReq), .resumeReq(resumeReq),
        .debugBreak(debugBreak), .irqLines(irqLines), .debugMode(debugMode));

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            numErrors++;
        end
    endtask : check

    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : endSim

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    // one access; answer is registered, so it is visible right after the next edge
    task automatic access(input logic [11:0] a, input mttc_pkg::mttc_csrop_type o,
                          input logic [31:0] w);
        // let an edge pass so the strobe never drops and rises in one step
        tick();
        csrValid = 1'b1;
        csrAddr  = a;
        csrOp    = o;
        csrWdata = w;
        tick();
        csrValid = 1'b0;
        check("readValid", 32'h1, {31'h0, csrReadValid});
    endtask : access

    task automatic setDebug(input logic v);
        if (debugMode !== v) begin
            haltReq   = v;
            resumeReq = !v;
            tick();
            haltReq   = 1'b0;
            resumeReq = 1'b0;
        end
    endtask : setDebug

    task automatic fetchCheck(input logic [31:0] a, input logic m, input logic e);
        fetchAddr   = a;
        machineMode = m;
        fetchValid  = 1'b1;
        #1;
        check("debugBreak", {31'h0, e}, {31'h0, debugBreak});
        tick();
    endtask : fetchCheck

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        numErrors++;
        endSim();
    end

    initial begin
        {rst, csrValid, machineMode, trapTaken, trapIsIrq, mretValid} = 6'h28;
        {irqEnableWrite, irqEnableValue, fetchValid, haltReq, resumeReq} = 5'h00;
        {csrAddr, csrOp, csrWdata, trapCode, trapPc, irqDrive, fetchAddr} = '0;
        numErrors   = 0;
        totalChecks = 0;
        repeat (2) tick();
        rst = 1'b0;
        check("resetRdata", 32'h0, csrRdata);
        check("resetOut", 32'h0, {25'h0, csrReadValid, csrMapped, csrDenied, resumeValid,
                                  irqEnable, previousIrqEnable, debugBreak});
        check("resetPc", 32'h0, resumePc);
        $display("test reset done");
        foreach (rows[i]) begin
            setDebug(rows[i].dbg);
            machineMode = rows[i].mm;
            access(rows[i].addr, rows[i].op, rows[i].wdata);
            check("rdata", rows[i].rdata, csrRdata);
            check("flags", {30'h0, rows[i].flags}, {30'h0, csrMapped, csrDenied});
        end
        $display("test table done");
        foreach (pats[i]) begin
            irqDrive = pats[i];
            repeat (3) tick();
            access(mttc_pkg::ADDR_IRQ_PENDING, RD, 32'h0);
            check("pending", pats[i] & mttc_pkg::IRQ_PENDING_MASK, csrRdata);
        end
        $display("test pending done");
        {irqEnableWrite, irqEnableValue} = 2'b11;
        tick();
        {irqEnableWrite, trapTaken, trapIsIrq, trapCode, trapPc} = {3'b011, 5'h07, 32'h103};
        tick();
        trapTaken = 1'b0;
        check("resumePc", 32'h0000_0102, resumePc);
        check("enables", 32'h1, {30'h0, irqEnable, previousIrqEnable});
        access(mttc_pkg::ADDR_TRAP_CAUSE, RD, 32'h0);
        check("causeIrq", 32'h8000_0007, csrRdata);
        mretValid = 1'b1;
        #1;
        check("resume", 32'h0000_0103, {resumePc[31:1], resumeValid});
        tick();
        mretValid = 1'b0;
        check("irqEnable", 32'h1, {31'h0, irqEnable});
        {trapTaken, trapIsIrq, trapCode, trapPc} = {2'b10, 5'h02, 32'h200};
        tick();
        trapTaken = 1'b0;
        access(mttc_pkg::ADDR_TRAP_CAUSE, RD, 32'h0);
        check("causeExc", 32'h0000_0002, csrRdata);
        $display("test trap done");
        setDebug(1'b0);
        fetchCheck(32'h8000_1231, 1'b1, 1'b0);
        fetchCheck(32'h8000_1230, 1'b0, 1'b0);
        fetchCheck(32'h8000_1230, 1'b1, 1'b1);
        fetchCheck(32'h8000_1230, 1'b1, 1'b0);
        fetchValid = 1'b0;
        $display("test break done");
        access(mttc_pkg::ADDR_TRIGGER_INFO, RD, 32'h0);
        check("infoNone", 32'h0000_0001, rdataNone);
        $display("test info done");
        rst = 1'b1;
        tick();
        rst = 1'b0;
        check("rstAgain", 32'h0, {resumePc[31:1], irqEnable});
        access(mttc_pkg::ADDR_TRIGGER_CONTROL, RD, 32'h0);
        check("ctrlAgain", 32'h2800_1040, csrRdata);
        $display("test reset again done");
        endSim();
    end
endmodule : mttc_csr_bank_bench
